// >>> hw/nahi_host.sv
// Host controller driving an asynchronous NAND flash target.
//
// Notes on behaviour
// (R1) Command, address and data share one bidirectional 8-bit bus.
// (R2) Command cycles raise the command latch enable, nothing else does.
// (R3) Address cycles raise the address latch enable, nothing else does.
// (R4) Every command, address and write byte is clocked by write enable.
// (R5) Each read enable strobe returns one read byte.
// (R6) The device answers only while chip enable selects it.
// (R7) Write protect gates program and erase for the whole device.
// (R8) Ready/busy is open drain, low while busy, pulled high when ready.
// (R9) Block protection strap is sampled at power-up; high enables it.
// (R10) The reset command must be the first command after power-on.
// (R11) On-die correction starts disabled; set-feature toggles it.
// (R12) Page is 4096 plus 256 bytes; a block has 64 pages.
// (R13) Program and read by whole page; erase by whole block.
// (R14) Data and cache registers combine normally, split in cache mode.
// (R15) Data moves byte by byte through data and cache registers.
// (R16) Address bytes select either page row or byte column.
// (R17) Each die keeps a readable status byte.
// (R18) Copy works only within one plane.
// (R19) Permanent protection applies to blocks 47 down to 0 only.
// (R20) Page read ends within 115 us with correction, 30 us without.
// (R21) Program typically 240 or 200 us; erase typically 2 ms.
// (R22) Command latched on write enable rise with CE, ALE low, RE high.
// (R23) Read byte driven on read enable fall with CE, ALE, CLE low.
// (R24) Program and erase blocked while write protect is low.
// (R25) Host waits for ready before commands other than status reads; the code also lets reset through while busy.
// (R26) Device holds busy low until its operation completes.
`timescale 1ns/1ps
module nahi_host #(
    parameter int BUSY_TIMEOUT = nahi_pkg::ERASE_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic nand_ce_n,
    output logic nand_cle,
    output logic nand_ale,
    output logic nand_we_n,
    output logic nand_re_n,
    output logic nand_wp_n,
    output logic nand_strap,
    output logic [7:0] nand_io_out,
    output logic nand_io_oe,
    input wire logic [7:0] nand_io_in,
    input wire logic nand_rb_n
);
    typedef enum logic [1:0] {NAHI_IDLE, NAHI_SETUP, NAHI_PULSE,
        NAHI_HOLD} nahi_state_t;

    function automatic logic is_op(input logic [3:0] a);
        return a == nahi_pkg::REG_CMD || a == nahi_pkg::REG_ADDR ||
            a == nahi_pkg::REG_WDATA || a == nahi_pkg::REG_RDATA;
    endfunction

    // ------------------------------------------------------------
    // Pin inputs
    // ------------------------------------------------------------
    logic rb_level;
    logic [7:0] io_level;
    nahi_sync u_rb (.sys_clk(sys_clk), .rst_n(rst_n), .pin(nand_rb_n),
        .level(rb_level));
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_io
            nahi_sync u_io (.sys_clk(sys_clk), .rst_n(rst_n),
                .pin(nand_io_in[gi]), .level(io_level[gi]));
        end
    endgenerate

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    nahi_state_t state, next_state;
    nahi_pkg::nahi_op_t op, next_op;
    logic [2:0] ctrl, next_ctrl;
    logic [7:0] byte_out, next_byte_out;
    logic [7:0] rbyte, next_rbyte;
    logic [3:0] cnt, next_cnt;
    logic [31:0] bwait, next_bwait;
    logic reset_done, next_reset_done;
    logic timeout, next_timeout;
    logic refused, next_refused;
    logic [7:0] rdata_q, next_rdata_q;
    logic accept;
    logic is_status_cmd;

    assign is_status_cmd = reg_wdata == 8'h70 || reg_wdata == 8'h78;

    always_comb begin
        next_state = state;
        next_op = op;
        next_ctrl = ctrl;
        next_byte_out = byte_out;
        next_rbyte = rbyte;
        next_cnt = cnt;
        next_bwait = bwait;
        next_reset_done = reset_done;
        next_timeout = timeout;
        next_refused = refused;
        next_rdata_q = 8'h00;
        accept = 1'b0;
        if (reg_wr && reg_addr == nahi_pkg::REG_CTRL) begin
            next_ctrl = reg_wdata[2:0];
        end
        // Busy watchdog; the link holds no timer of its own.
        if (!rb_level) begin
            if (bwait == BUSY_TIMEOUT - 1) begin
                next_timeout = 1'b1;
            end else begin
                next_bwait = bwait + 32'h1;
            end
        end else begin
            next_bwait = 32'h0;
        end
        if (state == NAHI_IDLE && is_op(reg_addr) &&
            ((reg_wr && reg_addr != nahi_pkg::REG_RDATA) ||
             (reg_rd && reg_addr == nahi_pkg::REG_RDATA))) begin
            accept = 1'b1;
            // The first command must be reset; later commands other than status
            // and reset wait for the ready line, other cycles only for the reset.
            if (reg_addr == nahi_pkg::REG_CMD) begin
                if (!reset_done && reg_wdata != nahi_pkg::CMD_RESET) begin
                    accept = 1'b0; // [R10]
                end
                if (!rb_level && !is_status_cmd &&
                    reg_wdata != nahi_pkg::CMD_RESET) begin
                    accept = 1'b0; // [R25]
                end
            end else if (!reset_done) begin
                accept = 1'b0; // [R10]
            end
            if (!accept) begin
                next_refused = 1'b1;
            end
        end
        if (reg_wr && reg_addr == nahi_pkg::REG_STAT) begin
            next_refused = 1'b0;
            next_timeout = 1'b0;
        end
        unique case (state)
            NAHI_IDLE: begin
                if (accept) begin
                    next_state = NAHI_SETUP;
                    next_cnt = 4'(nahi_pkg::SETUP_CYC - 1);
                    // Set-feature passes through like any other command,
                    // so correction stays as the target last left it.
                    next_byte_out = reg_wdata; // [R11]
                    unique case (reg_addr)
                        nahi_pkg::REG_CMD: next_op = nahi_pkg::NAHI_OP_CMD;
                        nahi_pkg::REG_ADDR: next_op = nahi_pkg::NAHI_OP_ADDR;
                        nahi_pkg::REG_WDATA: next_op = nahi_pkg::NAHI_OP_WR;
                        default: next_op = nahi_pkg::NAHI_OP_RD;
                    endcase
                    if (reg_addr == nahi_pkg::REG_CMD &&
                        reg_wdata == nahi_pkg::CMD_RESET) begin
                        next_reset_done = 1'b1;
                    end
                end
            end
            NAHI_SETUP: begin
                if (cnt == 4'h0) begin
                    next_state = NAHI_PULSE;
                    next_cnt = 4'(nahi_pkg::PULSE_CYC - 1);
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            NAHI_PULSE: begin
                if (cnt == 4'h0) begin
                    next_state = NAHI_HOLD;
                    next_cnt = 4'(nahi_pkg::SETUP_CYC - 1);
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
            NAHI_HOLD: begin
                if (cnt == 4'h0) begin
                    next_state = NAHI_IDLE;
                    // The synchroniser lags the pins by about four cycles,
                    // so this strobe's byte has only settled by now.
                    if (op == nahi_pkg::NAHI_OP_RD) begin
                        next_rbyte = io_level; // [R5]
                    end
                end else begin
                    next_cnt = cnt - 4'h1;
                end
            end
        endcase
        if (reg_rd) begin
            unique case (reg_addr)
                nahi_pkg::REG_CTRL: next_rdata_q = {5'h0, ctrl};
                nahi_pkg::REG_STAT: next_rdata_q = {3'h0, refused, timeout,
                    reset_done, state == NAHI_IDLE, rb_level}; // [R8]
                nahi_pkg::REG_RDATA: next_rdata_q = rbyte;
                default: next_rdata_q = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state <= NAHI_IDLE;
            op <= nahi_pkg::NAHI_OP_CMD;
            ctrl <= nahi_pkg::CTRL_RESET;
            byte_out <= 8'h00;
            rbyte <= 8'h00;
            cnt <= 4'h0;
            bwait <= 32'h0;
            reset_done <= 1'b0;
            timeout <= 1'b0;
            refused <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            state <= next_state;
            op <= next_op;
            ctrl <= next_ctrl;
            byte_out <= next_byte_out;
            rbyte <= next_rbyte;
            cnt <= next_cnt;
            bwait <= next_bwait;
            reset_done <= next_reset_done;
            timeout <= next_timeout;
            refused <= next_refused;
            rdata_q <= next_rdata_q;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic active;
    assign active = state != NAHI_IDLE;
    assign reg_rdata = rdata_q;
    assign nand_ce_n = !(ctrl[nahi_pkg::CTRL_CE] || active); // [R6]
    assign nand_cle = active && op == nahi_pkg::NAHI_OP_CMD; // [R2] [R22]
    assign nand_ale = active && op == nahi_pkg::NAHI_OP_ADDR; // [R3]
    assign nand_we_n = !(state == NAHI_PULSE &&
        op != nahi_pkg::NAHI_OP_RD); // [R4]
    assign nand_re_n = !(state == NAHI_PULSE &&
        op == nahi_pkg::NAHI_OP_RD); // [R23]
    assign nand_io_out = byte_out; // [R1]
    assign nand_io_oe = active && op != nahi_pkg::NAHI_OP_RD; // [R1]
    assign nand_wp_n = ctrl[nahi_pkg::CTRL_WP]; // [R7] [R24]
    assign nand_strap = ctrl[nahi_pkg::CTRL_STRAP]; // [R9]

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_LATCH_EXCL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !(nand_cle && nand_ale)) // [R2]
        else $error("Both latch enables high.");
    AST_WE_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(nand_we_n) |-> !nand_ce_n && nand_re_n && nand_io_oe) // [R4]
        else $error("Write strobe without select or drive.");
    AST_WE_WIDTH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(nand_we_n) |-> !nand_we_n [*3] ##1 nand_we_n) // [R22]
        else $error("Write strobe width wrong.");
    AST_RE_WIDTH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(nand_re_n) |-> !nand_re_n [*3] ##1 nand_re_n) // [R5]
        else $error("Read strobe width wrong.");
    AST_RE_NO_DRIVE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !nand_re_n |-> !nand_io_oe && !nand_cle && !nand_ale) // [R23]
        else $error("Bus driven during read strobe.");
    AST_FIRST_RESET: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($fell(nand_we_n) && !reset_done) |-> 1'b0) // [R10]
        else $error("Strobe before reset command.");
    AST_CMD_STAT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (accept && reg_addr == nahi_pkg::REG_CMD && !rb_level)
        |-> reg_wdata == nahi_pkg::CMD_RESET || is_status_cmd) // [R25]
        else $error("Command issued while busy.");
    AST_CE_SELECT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        active |-> !nand_ce_n) // [R6]
        else $error("Cycle without chip enable.");
    AST_WP_FOLLOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (reg_wr && reg_addr == nahi_pkg::REG_CTRL)
        |=> nand_wp_n == $past(reg_wdata[1])) // [R24]
        else $error("Write protect pin not updated.");
endmodule // nahi_host

// >>> hw/nahi_pkg.sv
// Package of constants for the NAND async host interface controller.
package nahi_pkg;
    localparam int CLK_MHZ = 100;
    // Bus timing, in ns, and derived cycle counts (least times round up).
    localparam int T_SETUP_NS = 30;
    localparam int T_PULSE_NS = 30;
    localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
    // Array figures in us, longest busy to wait before timing out.
    localparam int T_READ_ECC_US = 115;
    localparam int T_READ_US = 30;
    localparam int T_PROG_ECC_US = 240;
    localparam int T_PROG_US = 200;
    localparam int T_ERASE_US = 2000;
    localparam int READ_ECC_CYC = T_READ_ECC_US * CLK_MHZ;
    localparam int READ_CYC = T_READ_US * CLK_MHZ;
    localparam int PROG_ECC_CYC = T_PROG_ECC_US * CLK_MHZ;
    localparam int PROG_CYC = T_PROG_US * CLK_MHZ;
    localparam int ERASE_CYC = T_ERASE_US * CLK_MHZ;
    // Page geometry.
    localparam int PAGE_MAIN = 4096;
    localparam int PAGE_SPARE = 256;
    localparam int PAGE_BYTES = PAGE_MAIN + PAGE_SPARE;
    localparam int PAGES_PER_BLOCK = 64;
    localparam int LOCK_TOP_BLOCK = 47;
    // Command bytes.
    localparam logic [7:0] CMD_RESET = 8'hff;
    // Host register offsets.
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h1;
    localparam logic [3:0] REG_CMD = 4'h2;
    localparam logic [3:0] REG_ADDR = 4'h3;
    localparam logic [3:0] REG_WDATA = 4'h4;
    localparam logic [3:0] REG_RDATA = 4'h5;
    // Control field positions.
    localparam int CTRL_CE = 0;
    localparam int CTRL_WP = 1;
    localparam int CTRL_STRAP = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    // Status field positions.
    localparam int ST_BUSY_PIN = 0;
    localparam int ST_IDLE = 1;
    localparam int ST_RESET_DONE = 2;
    localparam int ST_TIMEOUT = 3;
    localparam int ST_REFUSED = 4;
    typedef enum logic [1:0] {NAHI_OP_CMD, NAHI_OP_ADDR, NAHI_OP_WR,
        NAHI_OP_RD} nahi_op_t;
endpackage

// >>> hw/nahi_sync.sv
// Three-stage pin synchroniser with agreement of the last two stages.
`timescale 1ns/1ps
module nahi_sync (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;
    logic next_level;

    always_comb begin
        next_level = level;
        if (s2 == s3) begin
            next_level = s3;
        end
    end

    // Resets to high: an idle pulled-up ready line reads ready.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            level <= 1'b1;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            level <= next_level;
        end
    end
endmodule // nahi_sync

// >>> sim/nahi_host_tb_top.sv
// Self-checking bench for the NAND async host controller.
`timescale 1ns/1ps
module nahi_host_tb_top;
    typedef struct {nahi_pkg::nahi_op_t op; logic [7:0] val;} nahi_row_t;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, io_out, io_in, m_byte, m_stray, m_cmds, rv, c;
    logic ce_n, cle, ale, we_n, re_n, wp_n, strap, io_oe, rb_n;
    logic [7:0] bad = 8'h00;
    nahi_pkg::nahi_op_t m_kind;
    int mismatches = 0;
    int total_checks = 0;
    nahi_row_t rows [8] = '{'{nahi_pkg::NAHI_OP_CMD, 8'h00},
        '{nahi_pkg::NAHI_OP_ADDR, 8'h00}, '{nahi_pkg::NAHI_OP_ADDR, 8'h01},
        '{nahi_pkg::NAHI_OP_ADDR, 8'h02}, '{nahi_pkg::NAHI_OP_CMD, 8'h80},
        '{nahi_pkg::NAHI_OP_ADDR, 8'h47}, '{nahi_pkg::NAHI_OP_WR, 8'h5a},
        '{nahi_pkg::NAHI_OP_WR, 8'ha5}};
    always #5 sys_clk = ~sys_clk;
    nahi_host #(.BUSY_TIMEOUT(200)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nand_ce_n(ce_n),
        .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n), .nand_re_n(re_n),
        .nand_wp_n(wp_n), .nand_strap(strap), .nand_io_out(io_out),
        .nand_io_oe(io_oe), .nand_io_in(io_in), .nand_rb_n(rb_n));
    nahi_nand_model flash (.sys_clk(sys_clk), .ce_n(ce_n), .cle(cle),
        .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n), .io_out(io_out),
        .io_oe(io_oe), .io_in(io_in), .rb_n(rb_n), .kind(m_kind),
        .byte_seen(m_byte), .stray(m_stray), .cmds(m_cmds));
    // Both latches at once, or driving the bus under a read, is a fault.
    always @(posedge sys_clk) begin
        if ((cle && ale) || (!re_n && io_oe)) bad <= bad + 8'h01;
    end
    task automatic wrap_up;
        if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] e,
        input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Polls a status bit; a run-out bound counts as a mismatch.
    task automatic poll(input int bitpos, input int lim);
        logic [7:0] s;
        for (int n = 0; n < lim; n++) begin
            rd(nahi_pkg::REG_STAT, s);
            if (s[bitpos] === 1'b1) return;
        end
        mismatches++;
        wrap_up();
    endtask
    task automatic op(input logic [3:0] a, input logic [7:0] d);
        wr(a, d);
        poll(nahi_pkg::ST_IDLE, 40);
    endtask
    // The synchroniser hides a fresh busy for a few cycles, so wait first.
    task automatic wait_ready;
        repeat (8) @(posedge sys_clk);
        poll(nahi_pkg::ST_BUSY_PIN, 300);
    endtask
    // The byte of a strobe is fetched by the read that starts the next one.
    task automatic rd_byte(output logic [7:0] v);
        rd(nahi_pkg::REG_RDATA, v);
        poll(nahi_pkg::ST_IDLE, 40);
    endtask
    task automatic status(output logic [7:0] v);
        op(nahi_pkg::REG_CMD, 8'h70);
        rd_byte(v);
        rd_byte(v);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1 chk("pins", 8'h98, {ce_n, cle, ale, we_n, re_n, wp_n, strap, io_oe});
        rd(nahi_pkg::REG_STAT, rv);
        chk("stat0", 8'h03, rv);
        op(nahi_pkg::REG_CMD, 8'h70);
        rd(nahi_pkg::REG_STAT, rv);
        chk("early", 8'h13, rv);
        chk("cmds0", 8'h00, m_cmds);
        wr(nahi_pkg::REG_STAT, 8'h00);
        op(nahi_pkg::REG_CMD, nahi_pkg::CMD_RESET);
        chk("reset", nahi_pkg::CMD_RESET, m_byte);
        wait_ready;
        rd(nahi_pkg::REG_STAT, rv);
        chk("stat1", 8'h07, rv);
        foreach (rows[i]) begin
            op(rows[i].op == nahi_pkg::NAHI_OP_CMD ? nahi_pkg::REG_CMD :
                rows[i].op == nahi_pkg::NAHI_OP_ADDR ? nahi_pkg::REG_ADDR :
                nahi_pkg::REG_WDATA, rows[i].val);
            chk("kind", 8'(rows[i].op), 8'(m_kind));
            chk("byte", rows[i].val, m_byte);
        end
        op(nahi_pkg::REG_CMD, 8'h00);
        rd_byte(rv);
        rd_byte(rv);
        chk("rd0", 8'ha0, rv);
        rd_byte(rv);
        chk("rd1", 8'ha1, rv);
        wr(nahi_pkg::REG_CTRL, 8'h04);
        chk("strap", 8'h01, {wp_n, strap});
        op(nahi_pkg::REG_CMD, 8'h80);
        op(nahi_pkg::REG_CMD, 8'h10);
        status(rv);
        chk("st_wp", 8'h41, rv);
        wr(nahi_pkg::REG_CTRL, 8'h02);
        chk("wp", 8'h01, 8'(wp_n));
        op(nahi_pkg::REG_CMD, 8'h80);
        op(nahi_pkg::REG_CMD, 8'h10);
        repeat (8) @(posedge sys_clk);
        rd(nahi_pkg::REG_STAT, rv);
        chk("rb", 8'h00, 8'(rv[nahi_pkg::ST_BUSY_PIN]));
        c = m_cmds;
        op(nahi_pkg::REG_CMD, 8'h00);
        rd(nahi_pkg::REG_STAT, rv);
        chk("refused", 8'h01, 8'(rv[nahi_pkg::ST_REFUSED]));
        chk("cmds1", c, m_cmds);
        status(rv);
        chk("st_busy", 8'h80, rv);
        wait_ready;
        status(rv);
        chk("st_done", 8'hc0, rv);
        op(nahi_pkg::REG_CMD, 8'hd0);
        repeat (220) @(posedge sys_clk);
        rd(nahi_pkg::REG_STAT, rv);
        chk("timeout", 8'h01, 8'(rv[nahi_pkg::ST_TIMEOUT]));
        wait_ready;
        wr(nahi_pkg::REG_STAT, 8'h00);
        rd(nahi_pkg::REG_STAT, rv);
        chk("tmo_clr", 8'h07, rv);
        wr(nahi_pkg::REG_CTRL, 8'h03);
        chk("ce_on", 8'h00, 8'(ce_n));
        wr(nahi_pkg::REG_CTRL, 8'h00);
        chk("ce_off", 8'h01, 8'(ce_n));
        chk("stray", 8'h00, m_stray);
        chk("bus", 8'h00, bad);
        wrap_up();
    end
endmodule // nahi_host_tb_top

// >>> sim/nahi_nand_model.sv
// Behavioural model of the flash target on the multiplexed bus.
`timescale 1ns/1ps
module nahi_nand_model (
    input wire logic sys_clk,
    input wire logic ce_n,
    input wire logic cle,
    input wire logic ale,
    input wire logic we_n,
    input wire logic re_n,
    input wire logic wp_n,
    input wire logic [7:0] io_out,
    input wire logic io_oe,
    output logic [7:0] io_in,
    output logic rb_n,
    output nahi_pkg::nahi_op_t kind,
    output logic [7:0] byte_seen,
    output logic [7:0] stray,
    output logic [7:0] cmds
);
    time busy_end = 0;
    logic busy = 1'b0;
    logic fail = 1'b0;
    logic stat_mode = 1'b0;
    logic dev_oe = 1'b0;
    logic [7:0] dev_dq = 8'h00;
    logic [7:0] last = 8'h00;
    logic [7:0] rd_cnt = 8'ha0;
    logic armed = 1'b0;
    initial begin
        kind = nahi_pkg::NAHI_OP_CMD;
        byte_seen = 8'h00;
        stray = 8'h00;
        cmds = 8'h00;
    end
    // Pull-up makes the line high whenever the target stops pulling.
    assign rb_n = busy ? 1'b0 : 1'b1;
    // A released bus shows the inverse of its last level, never a copy.
    assign io_in = io_oe ? io_out : (dev_oe ? dev_dq : ~last);
    always @(posedge sys_clk) begin
        last <= io_in;
        busy <= ($time < busy_end);
    end
    // Only a rise after a real fall is a strobe; the rise out of the
    // unknown level at start-up is not one.
    always @(negedge we_n) armed = 1'b1;
    always @(posedge we_n) begin
        if (!armed) begin
            // Start-up edge, nothing latched.
        end else if (ce_n) begin
            stray <= stray + 8'h01;
        end else if (cle && !ale && re_n) begin
            kind <= nahi_pkg::NAHI_OP_CMD;
            byte_seen <= io_in;
            cmds <= cmds + 8'h01;
            case (io_in)
                8'hff: busy_end <= $time + 1000;
                8'h70: stat_mode <= 1'b1;
                8'h10: if (wp_n) busy_end <= $time + 1000;
                       else fail <= 1'b1;
                // Array times are scaled down to keep runs short.
                8'h30: busy_end <= $time + 300;
                8'hd0: if (wp_n) busy_end <= $time + 3000;
                       else fail <= 1'b1;
                default: begin
                    stat_mode <= 1'b0;
                    fail <= 1'b0;
                end
            endcase
        end else if (ale && !cle && re_n) begin
            kind <= nahi_pkg::NAHI_OP_ADDR;
            byte_seen <= io_in;
        end else if (!cle && !ale && re_n) begin
            kind <= nahi_pkg::NAHI_OP_WR;
            byte_seen <= io_in;
        end
    end
    always @(negedge re_n) begin
        if (!ce_n && !cle && !ale && we_n) begin
            dev_oe <= 1'b1;
            dev_dq <= stat_mode ? {wp_n, !busy, 5'h00, fail} : rd_cnt;
            if (!stat_mode) rd_cnt <= rd_cnt + 8'h01;
        end
    end
    always @(posedge re_n) dev_oe <= 1'b0;
endmodule // nahi_nand_model
